// *** verilog/hcl_pkg.sv ***
// constants and types for the hub configuration loader
// Operation
// RULE1 - no valid memory: default descriptors and ids
// RULE2 - one memory interface at a time; reduced-pin variant I2C only
// RULE3 - microwire memory only read; writes via I2C only
// RULE4 - each power-on reset: read memory, check sum, then load
// RULE5 - discard settings unless byte 04h equals id bytes sum plus one
// RULE6 - checksum sum wraps modulo 256 before comparison
// RULE7 - port-1 amber off while microwire memory attached
// RULE8 - vid bytes 00h/01h, pid bytes 02h/03h, low byte first
// RULE9 - byte 06h bits 4:1 mark non-removable ports; other bits zero
// RULE10 - byte 07h sets enabled port count 1 to 4, default 4; code falls back to the strap port count instead
// RULE11 - byte 08h is max power in 2 mA units, 00h-FAh, default 32h
// RULE12 - memory image holds FFh in reserved bytes, 0Bh holds FEh
// RULE13 - strings are length-prefixed at 10h, 40h and 70h
// RULE14 - internal reset released 2.7 us after core supply good
// RULE15 - bus supply plug, unplug or droop resets
// RULE16 - sample mode pin within 20 us: low individual, high ganged
// RULE17 - 50 to 60 ms after reset mode pin drives suspend flag
// RULE18 - power enable active-high if polarity strap 1, else low
// RULE19 - port-count straps 11:1, 10:2, 01:3, 00:4 ports
// RULE20 - strap_a straps high at reset mark ports non-removable
// RULE21 - clock straps 01:48 MHz, 10:27 MHz, 11:12 MHz reference
// RULE22 - clock strap 00 reserved, fall back to 12 MHz
// RULE23 - reduced-pin variant with memory keeps data pin as I2C data
package hcl_pkg;
   localparam int          CLK_MHZ       = 250;
   localparam int          POR_REL_NS    = 2700;
   localparam int          POR_REL_CYC   = POR_REL_NS * CLK_MHZ / 1000;
   localparam int          MODE_SMP_US   = 20;
   localparam int          MODE_SMP_CYC  = MODE_SMP_US * CLK_MHZ;
   localparam int          SUSP_OUT_MS   = 55;
   localparam int          SUSP_OUT_CYC  = SUSP_OUT_MS * CLK_MHZ * 1000;
   localparam int          I2C_KHZ       = 100;
   localparam int          I2C_QTR_CYC   = CLK_MHZ * 1000 / (I2C_KHZ * 4);
   localparam int          MW_QTR_CYC    = 1000;
   localparam logic [7:0]  OFS_VID_LO    = 8'h00;
   localparam logic [7:0]  OFS_VID_HI    = 8'h01;
   localparam logic [7:0]  OFS_PID_LO    = 8'h02;
   localparam logic [7:0]  OFS_PID_HI    = 8'h03;
   localparam logic [7:0]  OFS_CKSUM     = 8'h04;
   localparam logic [7:0]  OFS_REMOV     = 8'h06;
   localparam logic [7:0]  OFS_PORTS     = 8'h07;
   localparam logic [7:0]  OFS_MAXPWR    = 8'h08;
   localparam logic [7:0]  OFS_VSTR      = 8'h10;
   localparam logic [7:0]  OFS_PSTR      = 8'h40;
   localparam logic [7:0]  OFS_SSTR      = 8'h70;
   localparam logic [7:0]  LAST_BYTE     = 8'h7f;
   localparam logic [7:0]  CKSUM_BIAS    = 8'h01;
   localparam logic [2:0]  DEF_PORTS     = 3'h4;
   localparam logic [7:0]  DEF_MAXPWR    = 8'h32;
   localparam logic [7:0]  MAX_MAXPWR    = 8'hfa;
   localparam logic [4:1]  DEF_REMOV     = 4'h0;
   localparam logic [6:0]  I2C_DEV_ADDR  = 7'h50;
   localparam logic [1:0]  MW_READ_OP    = 2'h2;
   typedef enum logic [1:0] {
      HCL_REF_12 = 2'h0,
      HCL_REF_27 = 2'h1,
      HCL_REF_48 = 2'h2
   } hcl_ref_t;
endpackage

// *** verilog/hcl_i2c_rd.sv ***
// i2c random-address byte reader
`timescale 1ns/100ps
module hcl_i2c_rd #(
   parameter int QTR = hcl_pkg::I2C_QTR_CYC
) (
   input  wire logic       i_clk,
   input  wire logic       i_rst_b,
   input  wire logic       i_start,
   input  wire logic [7:0] i_addr,
   input  wire logic       i_sda,
   output logic            o_scl,
   output logic            o_sda_oe,
   output logic [7:0]      o_data,
   output logic            o_done,
   output logic            o_nack
);
   initial if (QTR < 2) $error("quarter period too short");
   // sda_oe high pulls the wire low
   typedef enum logic [2:0] {
      HCL_I_IDLE = 3'h0, HCL_I_START = 3'h1, HCL_I_BIT = 3'h2,
      HCL_I_STOP = 3'h3, HCL_I_DONE = 3'h4
   } hcl_i_t;
   hcl_i_t      st_q;
   logic [15:0] qc_q;
   logic [1:0]  ph_q;
   logic [5:0]  bit_q;
   logic [8:0]  sh_q;
   logic        rs_q;
   logic        nack_q;
   logic        tick;
   assign tick = (qc_q == 16'(QTR - 1));
   // frame: S dev+w addr Sr dev+r data nack P; bit_q counts bits across the 9-bit slots
   function automatic logic [8:0] slot(input logic [5:0] n,
                                       input logic [7:0] a);
      unique case (n)
         6'h0:    slot = {hcl_pkg::I2C_DEV_ADDR, 1'b0, 1'b1};
         6'h1:    slot = {a, 1'b1};
         6'h2:    slot = {hcl_pkg::I2C_DEV_ADDR, 1'b1, 1'b1};
         default: slot = 9'h1ff;
      endcase
   endfunction
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         qc_q <= 16'h0;
      end else if (st_q == HCL_I_IDLE || tick) begin
         qc_q <= 16'h0;
      end else begin
         qc_q <= qc_q + 16'h1;
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_q <= HCL_I_IDLE; ph_q <= 2'h0; bit_q <= 6'h0; sh_q <= 9'h0;
         rs_q <= 1'b0; nack_q <= 1'b0; o_scl <= 1'b1; o_sda_oe <= 1'b0;
         o_data <= 8'h0; o_done <= 1'b0; o_nack <= 1'b0;
      end else begin
         o_done <= 1'b0;
         unique case (st_q)
            HCL_I_IDLE: if (i_start) begin
               st_q <= HCL_I_START; ph_q <= 2'h0; bit_q <= 6'h0;
               rs_q <= 1'b0; nack_q <= 1'b0;
               o_scl <= 1'b1; o_sda_oe <= 1'b0;
            end
            HCL_I_START: if (tick) begin
               ph_q <= ph_q + 2'h1;
               unique case (ph_q)
                  2'h0: o_scl <= 1'b1;
                  2'h1: o_sda_oe <= 1'b1;
                  2'h2: o_scl <= 1'b0;
                  2'h3: begin
                     st_q <= HCL_I_BIT;
                     sh_q <= slot(rs_q ? 6'h2 : 6'h0, i_addr);
                     bit_q <= rs_q ? 6'h12 : 6'h0;
                  end
               endcase
            end
            HCL_I_BIT: if (tick) begin
               ph_q <= ph_q + 2'h1;
               unique case (ph_q)
                  2'h0: o_sda_oe <= ~sh_q[8];
                  2'h1: o_scl <= 1'b1;
                  2'h2: begin
                     if (bit_q[3:0] == 4'h8 || bit_q == 6'h11 ||
                         bit_q == 6'h1a) begin
                        if (bit_q != 6'h23 && i_sda) nack_q <= 1'b1;
                     end
                     if (bit_q >= 6'h1b && bit_q <= 6'h22) begin
                        o_data <= {o_data[6:0], i_sda};
                     end
                  end
                  2'h3: begin
                     o_scl <= 1'b0;
                     bit_q <= bit_q + 6'h1;
                     sh_q <= {sh_q[7:0], 1'b1};
                     if (bit_q == 6'h8) begin
                        sh_q <= slot(6'h1, i_addr);
                     end else if (bit_q == 6'h11) begin
                        rs_q <= 1'b1; st_q <= HCL_I_START;
                        o_sda_oe <= 1'b0;
                     end else if (bit_q == 6'h23) begin
                        st_q <= HCL_I_STOP; o_sda_oe <= 1'b1;
                     end
                  end
               endcase
            end
            HCL_I_STOP: if (tick) begin
               ph_q <= ph_q + 2'h1;
               if (ph_q == 2'h1) o_scl <= 1'b1;
               if (ph_q == 2'h2) o_sda_oe <= 1'b0;
               if (ph_q == 2'h3) st_q <= HCL_I_DONE;
            end
            HCL_I_DONE: begin
               st_q <= HCL_I_IDLE; o_done <= 1'b1; o_nack <= nack_q;
            end
            default: st_q <= HCL_I_IDLE;
         endcase
      end
   end
endmodule

// *** verilog/hcl_mw_rd.sv ***
// microwire read-only byte reader
`timescale 1ns/100ps
module hcl_mw_rd #(
   parameter int QTR = hcl_pkg::MW_QTR_CYC
) (
   input  wire logic       i_clk,
   input  wire logic       i_rst_b,
   input  wire logic       i_start,
   input  wire logic [7:0] i_addr,
   input  wire logic       i_do,
   output logic            o_cs,
   output logic            o_sk,
   output logic            o_di,
   output logic [7:0]      o_data,
   output logic            o_done
);
   initial if (QTR < 2) $error("quarter period too short");
   // start bit, read opcode, 7-bit address, dummy zero, 8 data bits
   logic [15:0] qc_q;
   logic [1:0]  ph_q;
   logic [4:0]  n_q;
   logic [9:0]  sh_q;
   logic        busy_q;
   logic        tick;
   assign tick = (qc_q == 16'(QTR - 1));
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         qc_q <= 16'h0;
      end else if (!busy_q || tick) begin
         qc_q <= 16'h0;
      end else begin
         qc_q <= qc_q + 16'h1;
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         busy_q <= 1'b0; ph_q <= 2'h0; n_q <= 5'h0; sh_q <= 10'h0;
         o_cs <= 1'b0; o_sk <= 1'b0; o_di <= 1'b0;
         o_data <= 8'h0; o_done <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (!busy_q) begin
            if (i_start) begin
               busy_q <= 1'b1; ph_q <= 2'h0; n_q <= 5'h0; o_cs <= 1'b1;
               sh_q <= {1'b1, hcl_pkg::MW_READ_OP, i_addr[6:0]}; // RULE3
            end
         end else if (tick) begin
            ph_q <= ph_q + 2'h1;
            unique case (ph_q)
               2'h0: o_di <= sh_q[9];
               2'h1: o_sk <= 1'b1;
               2'h2: if (n_q >= 5'hb) o_data <= {o_data[6:0], i_do};
               2'h3: begin
                  o_sk <= 1'b0;
                  sh_q <= {sh_q[8:0], 1'b0};
                  n_q <= n_q + 5'h1;
                  if (n_q == 5'h12) begin
                     busy_q <= 1'b0; o_cs <= 1'b0; o_di <= 1'b0;
                     o_done <= 1'b1;
                  end
               end
            endcase
         end
      end
   end
endmodule

// *** verilog/hcl_loader.sv ***
// power-on configuration loader: memory read, checksum, straps
`timescale 1ns/100ps
module hcl_loader #(
   parameter int            POR_CYC   = hcl_pkg::POR_REL_CYC,
   parameter int            SMP_CYC   = hcl_pkg::MODE_SMP_CYC,
   parameter int            SUSP_CYC  = hcl_pkg::SUSP_OUT_CYC,
   parameter int            I2C_QTR   = hcl_pkg::I2C_QTR_CYC,
   parameter int            MW_QTR    = hcl_pkg::MW_QTR_CYC,
   parameter logic [15:0]   DEF_VID   = 16'h1234, // arbitrary value
   parameter logic [15:0]   DEF_PID   = 16'h5678, // arbitrary value
   parameter logic          REDUCED   = 1'b0
) (
   input  wire logic        i_clk,
   input  wire logic        i_rst_b,
   input  wire logic        i_core_pwr_good,
   input  wire logic        i_vbus_reset_b,
   input  wire logic        i_use_microwire,
   input  wire logic        i_mem_present,
   input  wire logic        i_sda,
   input  wire logic        i_mw_do,
   input  wire logic        i_mode_pin,
   input  wire logic        i_switch_polarity_strap,
   input  wire logic        i_port_count_strap_hi,
   input  wire logic        i_port_count_strap_lo,
   input  wire logic [4:1]  i_strap_a,
   input  wire logic        i_osc48_select_strap,
   input  wire logic        i_osc27_select_strap,
   input  wire logic        i_hub_suspended,
   input  wire logic [4:1]  i_port_power_req,
   input  wire logic        i_port1_amber_req,
   output logic            o_scl,
   output logic            o_sda_oe,
   output logic            o_mw_cs,
   output logic            o_mw_sk,
   output logic            o_mw_di,
   output logic            o_mode_pin_out,
   output logic            o_mode_pin_oe,
   output logic            o_ganged,
   output logic [4:1]      o_power_switch_enable,
   output logic            o_power_switch_enable_oe,
   output logic            o_port1_amber_led,
   output logic [15:0]     o_vid,
   output logic [15:0]     o_pid,
   output logic [7:0]      o_removable_port_map,
   output logic [2:0]      o_port_count,
   output logic [7:0]      o_max_power,
   output logic [7:0]      o_vstr_len,
   output logic [7:0]      o_pstr_len,
   output logic [7:0]      o_sstr_len,
   output logic [1:0]      o_ref_clk_sel,
   output logic            o_cfg_from_mem,
   output logic            o_cfg_done
);
   initial if (SMP_CYC < 1 || SUSP_CYC <= SMP_CYC) $error("bad timing");

   typedef enum logic [2:0] {
      HCL_WAIT = 3'h0, HCL_RD = 3'h1, HCL_WT = 3'h2,
      HCL_CHK = 3'h3, HCL_DONE = 3'h4
   } hcl_st_t;

   // internal reset: power-good delay and bus-supply reset
   logic [15:0] por_q;
   logic        pg_s1_q, pg_s2_q, vb_s1_q, vb_s2_q;
   logic        por_ok_q;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pg_s1_q <= 1'b0; pg_s2_q <= 1'b0;
         vb_s1_q <= 1'b0; vb_s2_q <= 1'b0;
      end else begin
         pg_s1_q <= i_core_pwr_good; pg_s2_q <= pg_s1_q;
         vb_s1_q <= i_vbus_reset_b;  vb_s2_q <= vb_s1_q;
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         por_q <= 16'h0; por_ok_q <= 1'b0;
      end else if (!pg_s2_q || !vb_s2_q) begin // RULE14 RULE15
         por_q <= 16'h0; por_ok_q <= 1'b0;
      end else if (por_q == 16'(POR_CYC - 1)) begin
         por_ok_q <= 1'b1; // RULE14
      end else begin
         por_q <= por_q + 16'h1;
      end
   end
   logic run;
   assign run = por_ok_q;

   // pin synchronisers
   logic [13:0] st1_q, st2_q;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st1_q <= 14'h0; st2_q <= 14'h0;
      end else begin
         st1_q <= {i_sda, i_mw_do, i_mode_pin, i_switch_polarity_strap,
                   i_port_count_strap_hi, i_port_count_strap_lo, i_strap_a,
                   i_osc48_select_strap, i_osc27_select_strap,
                   i_use_microwire, i_mem_present};
         st2_q <= st1_q;
      end
   end

   // uptime since internal reset release
   logic [31:0] up_q;
   logic        smp_q, susp_q, pol_q;
   logic [4:1]  fixed_q;
   logic [2:0]  strap_ports_q;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         up_q <= 32'h0;
      end else if (!run) begin
         up_q <= 32'h0;
      end else if (up_q != 32'(SUSP_CYC)) begin
         up_q <= up_q + 32'h1;
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         smp_q <= 1'b0; o_ganged <= 1'b0; pol_q <= 1'b0;
         fixed_q <= 4'h0; strap_ports_q <= hcl_pkg::DEF_PORTS;
         o_ref_clk_sel <= hcl_pkg::HCL_REF_12;
      end else if (!run) begin
         smp_q <= 1'b0;
      end else if (!smp_q && up_q == 32'(SMP_CYC - 1)) begin
         smp_q <= 1'b1;
         o_ganged <= st2_q[11]; // RULE16
         pol_q <= st2_q[10]; // RULE18
         fixed_q <= st2_q[7:4]; // RULE20
         unique case (st2_q[9:8]) // RULE19
            2'h3: strap_ports_q <= 3'h1;
            2'h2: strap_ports_q <= 3'h2;
            2'h1: strap_ports_q <= 3'h3;
            2'h0: strap_ports_q <= 3'h4;
         endcase
         unique case (st2_q[3:2]) // RULE21
            2'h1: o_ref_clk_sel <= hcl_pkg::HCL_REF_48;
            2'h2: o_ref_clk_sel <= hcl_pkg::HCL_REF_27;
            default: o_ref_clk_sel <= hcl_pkg::HCL_REF_12; // RULE22
         endcase
      end
   end

   // mode pin turns suspend-flag output
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         susp_q <= 1'b0; o_mode_pin_oe <= 1'b0; o_mode_pin_out <= 1'b0;
      end else if (!run) begin
         susp_q <= 1'b0; o_mode_pin_oe <= 1'b0; o_mode_pin_out <= 1'b0;
      end else begin
         if (up_q == 32'(SUSP_CYC)) susp_q <= 1'b1; // RULE17
         o_mode_pin_oe <= susp_q;
         o_mode_pin_out <= susp_q & i_hub_suspended; // RULE17
      end
   end

   // one memory interface; reduced variant is i2c only
   logic mw_sel;
   assign mw_sel = st2_q[1] & ~REDUCED; // RULE2
   hcl_st_t     st_q;
   logic [7:0]  addr_q;
   logic [7:0]  sum_q;
   logic [7:0]  img_vl_q, img_vh_q, img_pl_q, img_ph_q, img_ck_q;
   logic [7:0]  img_rm_q, img_pn_q, img_mp_q;
   logic [7:0]  img_vs_q, img_ps_q, img_ss_q;
   logic        go_q, nack_seen_q;
   logic [7:0]  i2c_data, mw_data, rd_data;
   logic        i2c_done, i2c_nack, mw_done, rd_done;
   assign rd_data = mw_sel ? mw_data : i2c_data;
   assign rd_done = mw_sel ? mw_done : i2c_done;
   logic i2c_scl, i2c_sda_oe, mw_cs, mw_sk, mw_di;

   hcl_i2c_rd #(.QTR(I2C_QTR)) u_i2c (
      .i_clk    (i_clk),
      .i_rst_b  (i_rst_b),
      .i_start  (go_q & ~mw_sel),
      .i_addr   (addr_q),
      .i_sda    (st2_q[13]),
      .o_scl    (i2c_scl),
      .o_sda_oe (i2c_sda_oe),
      .o_data   (i2c_data),
      .o_done   (i2c_done),
      .o_nack   (i2c_nack)
   );
   hcl_mw_rd #(.QTR(MW_QTR)) u_mw (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_start (go_q & mw_sel),
      .i_addr  (addr_q),
      .i_do    (st2_q[12]),
      .o_cs    (mw_cs),
      .o_sk    (mw_sk),
      .o_di    (mw_di),
      .o_data  (mw_data),
      .o_done  (mw_done)
   );

   // only string lengths are kept; text stays in memory
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_q <= HCL_WAIT; addr_q <= 8'h0; go_q <= 1'b0;
         nack_seen_q <= 1'b0;
         img_vl_q <= 8'h0; img_vh_q <= 8'h0; img_pl_q <= 8'h0;
         img_ph_q <= 8'h0; img_ck_q <= 8'h0; img_rm_q <= 8'h0;
         img_pn_q <= 8'h0; img_mp_q <= 8'h0; img_vs_q <= 8'h0;
         img_ps_q <= 8'h0; img_ss_q <= 8'h0;
      end else if (!run) begin
         st_q <= HCL_WAIT; go_q <= 1'b0; nack_seen_q <= 1'b0; // RULE4
      end else begin
         go_q <= 1'b0;
         unique case (st_q)
            HCL_WAIT: if (smp_q) begin
               addr_q <= hcl_pkg::OFS_VID_LO;
               st_q <= st2_q[0] ? HCL_RD : HCL_CHK;
            end
            HCL_RD: begin
               go_q <= 1'b1; st_q <= HCL_WT;
            end
            HCL_WT: if (rd_done) begin
               if (!mw_sel && i2c_nack) nack_seen_q <= 1'b1;
               unique case (addr_q) // RULE8 RULE13
                  hcl_pkg::OFS_VID_LO: img_vl_q <= rd_data;
                  hcl_pkg::OFS_VID_HI: img_vh_q <= rd_data;
                  hcl_pkg::OFS_PID_LO: img_pl_q <= rd_data;
                  hcl_pkg::OFS_PID_HI: img_ph_q <= rd_data;
                  hcl_pkg::OFS_CKSUM:  img_ck_q <= rd_data;
                  hcl_pkg::OFS_REMOV:  img_rm_q <= rd_data;
                  hcl_pkg::OFS_PORTS:  img_pn_q <= rd_data;
                  hcl_pkg::OFS_MAXPWR: img_mp_q <= rd_data;
                  hcl_pkg::OFS_VSTR:   img_vs_q <= rd_data;
                  hcl_pkg::OFS_PSTR:   img_ps_q <= rd_data;
                  hcl_pkg::OFS_SSTR:   img_ss_q <= rd_data;
                  default: ;
               endcase
               if (addr_q == hcl_pkg::OFS_SSTR) begin
                  st_q <= HCL_CHK;
               end else begin
                  addr_q <= addr_q + 8'h1; st_q <= HCL_RD;
               end
            end
            HCL_CHK: st_q <= HCL_DONE;
            HCL_DONE: ;
            default: st_q <= HCL_WAIT;
         endcase
      end
   end

   // eight-bit sum wraps before compare
   assign sum_q = img_vl_q + img_vh_q + img_pl_q + img_ph_q
                + hcl_pkg::CKSUM_BIAS; // RULE6
   logic valid;
   assign valid = st2_q[0] && !nack_seen_q && sum_q == img_ck_q; // RULE5

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_vid <= DEF_VID; o_pid <= DEF_PID;
         o_removable_port_map <= 8'h0; o_port_count <= hcl_pkg::DEF_PORTS;
         o_max_power <= hcl_pkg::DEF_MAXPWR; o_vstr_len <= 8'h0;
         o_pstr_len <= 8'h0; o_sstr_len <= 8'h0;
         o_cfg_from_mem <= 1'b0; o_cfg_done <= 1'b0;
      end else if (!run) begin
         o_cfg_done <= 1'b0; o_cfg_from_mem <= 1'b0;
      end else if (st_q == HCL_CHK) begin
         o_cfg_done <= 1'b1;
         o_cfg_from_mem <= valid;
         if (valid) begin // RULE4
            o_vid <= {img_vh_q, img_vl_q}; // RULE8
            o_pid <= {img_ph_q, img_pl_q};
            o_removable_port_map <= {3'h0,
                                     img_rm_q[4:1] | fixed_q, 1'b0}; // RULE9
            o_port_count <= (img_pn_q >= 8'h1 && img_pn_q <= 8'h4) ?
                            img_pn_q[2:0] : strap_ports_q; // RULE10
            o_max_power <= (img_mp_q <= hcl_pkg::MAX_MAXPWR) ?
                           img_mp_q : hcl_pkg::DEF_MAXPWR; // RULE11
            o_vstr_len <= img_vs_q; // RULE13
            o_pstr_len <= img_ps_q;
            o_sstr_len <= img_ss_q;
         end else begin // RULE1
            o_vid <= DEF_VID; o_pid <= DEF_PID;
            o_removable_port_map <= {3'h0, fixed_q, 1'b0}; // RULE20
            o_port_count <= strap_ports_q;
            o_max_power <= hcl_pkg::DEF_MAXPWR;
            o_vstr_len <= 8'h0; o_pstr_len <= 8'h0; o_sstr_len <= 8'h0;
         end
      end
   end

   // shared data pin stays i2c on reduced variant with memory present
   logic sda_is_mem;
   assign sda_is_mem = REDUCED && st2_q[0]; // RULE23
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_scl <= 1'b1; o_sda_oe <= 1'b0;
         o_mw_cs <= 1'b0; o_mw_sk <= 1'b0; o_mw_di <= 1'b0;
         o_power_switch_enable <= 4'h0; o_power_switch_enable_oe <= 1'b0;
         o_port1_amber_led <= 1'b0;
      end else begin
         o_scl <= i2c_scl;
         o_sda_oe <= i2c_sda_oe;
         o_mw_cs <= mw_cs; o_mw_sk <= mw_sk; o_mw_di <= mw_di;
         // RULE18
         o_power_switch_enable <= pol_q ? i_port_power_req
                                        : ~i_port_power_req;
         o_power_switch_enable_oe <= o_cfg_done & ~sda_is_mem; // RULE23
         o_port1_amber_led <= i_port1_amber_req & ~mw_sel; // RULE7
      end
   end
endmodule

// *** verification/hcl_loader_monitor.sv ***
// port-level assertions for the configuration loader
`timescale 1ns/100ps
module hcl_loader_monitor #(
   parameter logic [15:0] DEF_VID = 16'h1234,
   parameter logic [15:0] DEF_PID = 16'h5678
) (
   input logic        i_clk, i_rst_b, i_use_microwire, i_switch_polarity_strap,
   input logic [4:1]  i_port_power_req, o_power_switch_enable,
   input logic        o_sda_oe, o_mw_cs, o_mw_sk, o_mw_di, o_port1_amber_led,
   input logic        o_power_switch_enable_oe, o_cfg_done, o_cfg_from_mem,
   input logic [15:0] o_vid, o_pid,
   input logic [7:0]  o_removable_port_map, o_max_power,
   input logic [2:0]  o_port_count
);
   logic [1:0] sk_cnt_q;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   // saturates past the opcode
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) sk_cnt_q <= 2'h0;
      else if (!o_mw_cs) sk_cnt_q <= 2'h0;
      else if ($rose(o_mw_sk) && sk_cnt_q != 2'h3) sk_cnt_q <= sk_cnt_q + 2'h1;
   end
   sequence sk_up;
      $rose(o_mw_sk) && o_mw_cs;
   endsequence
   AST_AMBER_OFF: assert property (i_use_microwire [*4] |->
      !o_port1_amber_led) else $error("amber on");
   AST_ONE_IF: assert property (i_use_microwire [*4] |->
      !o_sda_oe) else $error("sda driven");
   AST_START_OP: assert property (sk_up ##0 sk_cnt_q < 2'h2 |->
      o_mw_di) else $error("start bit");
   AST_READ_OP: assert property (sk_up ##0 sk_cnt_q == 2'h2 |->
      !o_mw_di) else $error("not read op");
   AST_DEF_IDS: assert property ($rose(o_cfg_done) &&
      !o_cfg_from_mem |-> o_vid == DEF_VID && o_pid == DEF_PID)
      else $error("default ids");
   AST_PORTS: assert property (o_cfg_done |->
      o_port_count inside {[1:4]}) else $error("port count");
   AST_MAXPWR: assert property (o_cfg_done |->
      o_max_power <= 8'hfa) else $error("max power");
   AST_REMOV: assert property (o_cfg_done |->
      o_removable_port_map[0] == 1'b0 && o_removable_port_map[7:5] == 3'h0)
      else $error("removable map");
   AST_POL: assert property (o_power_switch_enable_oe |->
      o_power_switch_enable == (i_switch_polarity_strap ? i_port_power_req
      : ~i_port_power_req)) else $error("polarity");
endmodule
bind hcl_loader hcl_loader_monitor #(.DEF_VID(DEF_VID), .DEF_PID(DEF_PID))
   u_mon (.*);

// *** verification/hcl_mw_mem.sv ***
// microwire memory model
`timescale 1ns/100ps
module hcl_mw_mem (
   input  logic i_cs,
   input  logic i_sk,
   input  logic i_di,
   output logic o_do
);
   logic [7:0] mem [128];
   logic [6:0] addr_q;
   int         cnt_q = 0;
   initial o_do = 1'b0;
   always @(posedge i_cs) cnt_q = 0;
   // deselected: output flips
   always @(negedge i_cs) o_do <= ~o_do;
   always @(posedge i_sk) begin
      if (i_cs) begin
         cnt_q = cnt_q + 1;
         if (cnt_q > 3 && cnt_q < 11) addr_q = {addr_q[5:0], i_di};
         if (cnt_q == 11) o_do <= 1'b0;
         else if (cnt_q > 11 && cnt_q < 20) o_do <= mem[addr_q][19 - cnt_q];
         else o_do <= ~o_do;
      end
   end
endmodule

// *** verification/test_hcl_loader.sv ***
// bench for the configuration loader
`timescale 1ns/100ps
module test_hcl_loader;
   logic i_clk = 1'b0, i_rst_b = 1'b0, i_core_pwr_good = 1'b1, i_sda = 1'b1;
   logic i_vbus_reset_b = 1'b1, i_use_microwire = 1'b1, i_mem_present = 1'b1;
   logic i_port1_amber_req = 1'b1, i_switch_polarity_strap, i_hub_suspended;
   logic i_port_count_strap_hi, i_port_count_strap_lo, mode_strap;
   logic i_osc48_select_strap, i_osc27_select_strap, o_port1_amber_led;
   logic [4:1] i_strap_a, i_port_power_req, o_power_switch_enable;
   logic o_scl, o_sda_oe, o_mw_cs, o_mw_sk, o_mw_di, o_mode_pin_out;
   logic o_mode_pin_oe, o_ganged, o_power_switch_enable_oe, o_cfg_done;
   logic o_cfg_from_mem;
   logic [15:0] o_vid, o_pid;
   logic [7:0] o_removable_port_map, o_max_power, o_vstr_len, o_pstr_len;
   logic [7:0] o_sstr_len;
   logic [2:0] o_port_count;
   logic [1:0] o_ref_clk_sel;
   wire i_mw_do;
   wire i_mode_pin = o_mode_pin_oe ? o_mode_pin_out : mode_strap;
   int miscompares = 0, cmp_count = 0;
   always #2 i_clk = ~i_clk;
   hcl_loader #(.POR_CYC(10), .SMP_CYC(20), .SUSP_CYC(100), .I2C_QTR(4),
      .MW_QTR(4)) u_hcl_loader (.*);
   hcl_mw_mem u_hcl_mw_mem (.i_cs(o_mw_cs), .i_sk(o_mw_sk), .i_di(o_mw_di),
      .o_do(i_mw_do));
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic run(bit good);
      logic [7:0] m [9];
      logic [7:0] rm;
      i_rst_b <= 1'b0;
      {mode_strap, i_switch_polarity_strap, i_port_count_strap_hi,
       i_port_count_strap_lo, i_osc48_select_strap, i_osc27_select_strap,
       i_strap_a, i_port_power_req, i_hub_suspended} <= 15'($urandom);
      foreach (m[i]) m[i] = 8'($urandom);
      m[5] = 8'hff;
      m[7] = 8'($urandom_range(1, 4));
      m[8] = 8'($urandom_range(240, 255));
      m[4] = m[0] + m[1] + m[2] + m[3] + (good ? 8'h01 : 8'h02);
      for (int i = 0; i < 128; i++)
         u_hcl_mw_mem.mem[i] = (i == 11) ? 8'hfe : 8'hff;
      foreach (m[i]) u_hcl_mw_mem.mem[i] = m[i];
      {u_hcl_mw_mem.mem[16], u_hcl_mw_mem.mem[64]} = 16'h1122;
      u_hcl_mw_mem.mem[112] = 8'h33;
      repeat (16) @(posedge i_clk);
      i_rst_b <= 1'b1;
      for (int i = 0; i < 45000 && o_cfg_done !== 1'b1; i++) @(posedge i_clk);
      repeat (4) @(negedge i_clk);
      rm = {3'h0, i_strap_a | (good ? m[6][4:1] : 4'h0), 1'b0};
      chk("vid", o_vid, good ? {m[1], m[0]} : 16'h1234);
      chk("pid", o_pid, good ? {m[3], m[2]} : 16'h5678);
      chk("from_mem", o_cfg_from_mem, good);
      chk("ports", o_port_count, good ? m[7] : 3'h4 - {i_port_count_strap_hi,
          i_port_count_strap_lo});
      chk("power", o_max_power,
          good && m[8] < 8'hfb ? m[8] : 8'h32);
      chk("removable", o_removable_port_map, rm);
      chk("ref", o_ref_clk_sel, (i_osc48_select_strap ^ i_osc27_select_strap) ?
          {i_osc27_select_strap, i_osc48_select_strap} : 2'h0);
      chk("ganged", o_ganged, mode_strap);
      chk("suspend", {o_mode_pin_oe, o_mode_pin_out},
          {1'b1, i_hub_suspended});
      chk("amber", o_port1_amber_led, 1'b0);
      chk("pse", o_power_switch_enable, i_switch_polarity_strap ?
          i_port_power_req : ~i_port_power_req);
      chk("strings", {o_vstr_len, o_pstr_len, o_sstr_len},
          good ? 24'h112233 : 24'h0);
   endtask
   initial begin
      void'($urandom(32'hdbf5));
      run(1'b1);
      @(posedge i_clk);
      run(1'b0);
      report_and_stop();
   end
   initial begin
      repeat (100000) @(posedge i_clk);
      miscompares++;
      report_and_stop();
   end
endmodule
